/* verilog/adcs_cfg.svh */
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define ADCS_OFF_CTRL   4'h0
`define ADCS_OFF_RESULT 4'h4
`define ADCS_OFF_STATUS 4'h8
`define ADCS_CTRL_PWR   0
`define ADCS_CTRL_GO    1
`define ADCS_CTRL_IEN   2
`define ADCS_CTRL_CHLO  3
`define ADCS_CTRL_SELLO 6
`define ADCS_CTRL_RST   8'h00
`define ADCS_RESULT_RST 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define ADCS_CLK_NS     40
`define ADCS_RC_TAD_NS  4000
`define ADCS_RC_HALF    ((`ADCS_RC_TAD_NS / 2) / `ADCS_CLK_NS)
`define ADCS_HALF_2OSC  1
`define ADCS_HALF_8OSC  4
`define ADCS_HALF_32OSC 16
`define ADCS_INSTR_CYC  4
`define ADCS_SETUP_HALF 3
`define ADCS_LAST_HALF  18
`define ADCS_HOLD_HALF  4
`endif

/* verilog/adcs_pkg.sv */
package adcs_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_DELAY = 2'h1,
        ST_CONV  = 2'h2,
        ST_HOLD  = 2'h3
    } adcs_state_t;
    typedef enum logic [1:0] {
        SEL_2OSC  = 2'h0,
        SEL_8OSC  = 2'h1,
        SEL_32OSC = 2'h2,
        SEL_RC    = 2'h3
    } adcs_clksel_t;
endpackage

/* verilog/adcs_seq.sv */
`timescale 1ns/1ps
`include "adcs_cfg.svh"
module adcs_seq (
    input  wire logic        i_sys_clk,     // system clock
    input  wire logic        i_reset_n,     // async reset
    input  wire logic        i_sleep,       // core in sleep state
    input  wire logic        i_comp_high,   // comparator: input above trial
    output logic             o_powered,     // analog module powered
    output logic             o_sample,      // hold cap on channel
    output logic [1:0]       o_channel,     // selected channel
    output logic [7:0]       o_trial,       // trial code to comparator
    output logic             o_wake,        // wake-up request pulse
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [3:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // byte strobes
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    output logic [1:0]       s_axi_bresp,   // write response
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    input  wire logic [3:0]  s_axi_araddr,  // read address
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready,  // read data ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp    // read response
);
    adcs_pkg::adcs_state_t  state_reg;
    adcs_pkg::adcs_state_t  state_next;
    adcs_pkg::adcs_clksel_t sel;
    logic [7:0]  ctrl_reg;
    logic [7:0]  result_reg;
    logic        flag_reg;
    logic [6:0]  cnt_reg;
    logic [6:0]  limit;
    logic [4:0]  phase_reg;
    logic [7:0]  mask_reg;
    logic [7:0]  decided;
    logic        comp_meta_reg;
    logic        comp_sync_reg;
    logic        half_tick;
    logic        decide;
    logic        done;
    logic        osc_sleep;
    logic        go;
    logic        pwr;
    logic        aw_have_reg;
    logic        w_have_reg;
    logic [3:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_fire;
    logic        wr_ctrl;

    assign sel = adcs_pkg::adcs_clksel_t'(ctrl_reg[`ADCS_CTRL_SELLO +: 2]);
    assign go  = ctrl_reg[`ADCS_CTRL_GO];
    assign pwr = ctrl_reg[`ADCS_CTRL_PWR];
    // oscillator clocks stop in sleep, so only the RC clock survives
    assign osc_sleep = i_sleep && (sel != adcs_pkg::SEL_RC);

    // ----------------------------------------
    // bit period timing, in half periods
    // ----------------------------------------
    always_comb begin
        unique case (sel)
            adcs_pkg::SEL_2OSC:  limit = 7'(`ADCS_HALF_2OSC - 1);
            adcs_pkg::SEL_8OSC:  limit = 7'(`ADCS_HALF_8OSC - 1);
            adcs_pkg::SEL_32OSC: limit = 7'(`ADCS_HALF_32OSC - 1);
            adcs_pkg::SEL_RC:    limit = 7'(`ADCS_RC_HALF - 1);
        endcase
        if (state_reg == adcs_pkg::ST_DELAY) begin
            limit = 7'(`ADCS_INSTR_CYC - 1);
        end
    end

    // >= lets a switch to a faster divider take effect at once
    assign half_tick = (state_reg != adcs_pkg::ST_IDLE) && (cnt_reg >= limit);

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= 7'h00;
        end else if (half_tick || state_reg == adcs_pkg::ST_IDLE
                     || state_next != state_reg) begin
            // a mid-period abort would otherwise shorten the first hold period
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_reg <= 5'h00;
        end else if (state_next != state_reg) begin
            phase_reg <= 5'h00;
        end else if (half_tick) begin
            phase_reg <= phase_reg + 5'h01;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    assign done = (state_reg == adcs_pkg::ST_CONV) && half_tick && go && pwr && !osc_sleep
                  && (phase_reg == 5'(`ADCS_LAST_HALF));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            adcs_pkg::ST_IDLE: begin
                if (go && pwr && !osc_sleep) begin
                    state_next = (sel == adcs_pkg::SEL_RC) ? adcs_pkg::ST_DELAY
                                                           : adcs_pkg::ST_CONV;
                end
            end
            adcs_pkg::ST_DELAY: begin
                if (!go || !pwr || osc_sleep) begin
                    state_next = adcs_pkg::ST_HOLD;
                end else if (half_tick) begin
                    state_next = adcs_pkg::ST_CONV;
                end
            end
            adcs_pkg::ST_CONV: begin
                if (!go || !pwr || osc_sleep || done) begin
                    state_next = adcs_pkg::ST_HOLD;
                end
            end
            adcs_pkg::ST_HOLD: begin
                if (half_tick && phase_reg == 5'(`ADCS_HOLD_HALF - 1)) begin
                    state_next = adcs_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= adcs_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // successive approximation
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end else begin
            comp_meta_reg <= i_comp_high;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    // a bit is judged at the end of its period at whatever rate is in force
    assign decide  = (state_reg == adcs_pkg::ST_CONV) && half_tick && !phase_reg[0]
                     && (phase_reg > 5'(`ADCS_SETUP_HALF));
    assign decided = comp_sync_reg ? o_trial : (o_trial & ~mask_reg);

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask_reg <= 8'h00;
            o_trial  <= 8'h00;
        end else if (state_reg == adcs_pkg::ST_IDLE && state_next != adcs_pkg::ST_IDLE) begin
            mask_reg <= 8'h80;
            o_trial  <= 8'h80;
        end else if (decide) begin
            mask_reg <= mask_reg >> 1;
            o_trial  <= decided | (mask_reg >> 1);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            result_reg <= `ADCS_RESULT_RST;
        end else if (done) begin
            result_reg <= decided;
        end else if (wr_fire && awaddr_reg == `ADCS_OFF_RESULT && wstrb_reg[0]) begin
            result_reg <= wdata_reg[7:0];
        end
    end

    // ----------------------------------------
    // control and status
    // ----------------------------------------
    assign wr_ctrl = wr_fire && awaddr_reg == `ADCS_OFF_CTRL && wstrb_reg[0];

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_reg <= `ADCS_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wdata_reg[7:0];
                // go only takes when the module was already on
                ctrl_reg[`ADCS_CTRL_GO] <= wdata_reg[`ADCS_CTRL_GO]
                                           && wdata_reg[`ADCS_CTRL_PWR] && pwr;
            end
            if (done || (osc_sleep && state_reg != adcs_pkg::ST_IDLE)) begin
                ctrl_reg[`ADCS_CTRL_GO] <= 1'b0;
            end
        end
    end

    // set wins over a same-cycle write-one-to-clear
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flag_reg <= 1'b0;
        end else if (done) begin
            flag_reg <= 1'b1;
        end else if (wr_fire && awaddr_reg == `ADCS_OFF_STATUS && wstrb_reg[0]
                     && wdata_reg[0]) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_wake    <= 1'b0;
            o_powered <= 1'b0;
            o_sample  <= 1'b0;
            o_channel <= 2'h0;
        end else begin
            o_wake    <= done && i_sleep && ctrl_reg[`ADCS_CTRL_IEN];
            o_powered <= pwr && !osc_sleep;
            // the cap tracks whenever the module is powered and the next state is idle
            o_sample  <= pwr && !osc_sleep && state_next == adcs_pkg::ST_IDLE;
            o_channel <= ctrl_reg[`ADCS_CTRL_CHLO +: 2];
        end
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            awaddr_reg    <= 4'h0;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg   <= 1'b1;
                awaddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg   <= 1'b1;
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_reg == `ADCS_OFF_CTRL || awaddr_reg == `ADCS_OFF_RESULT
                                 || awaddr_reg == `ADCS_OFF_STATUS) ? 2'h0 : 2'h2;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            unique case (s_axi_araddr)
                `ADCS_OFF_CTRL:   s_axi_rdata <= {24'h00_0000, ctrl_reg};
                `ADCS_OFF_RESULT: s_axi_rdata <= {24'h00_0000, result_reg};
                `ADCS_OFF_STATUS: s_axi_rdata <= {29'h0000_0000, o_sample,
                                                  state_reg != adcs_pkg::ST_IDLE, flag_reg};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // adcs_seq

/* verification/adcs_seq_checker.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checks for the sequencer
// ----------------------------------------
module adcs_seq_checker (
    input wire logic        i_sys_clk,     // clock
    input wire logic        i_reset_n,     // reset
    input wire logic        i_sleep,       // sleep state
    input wire logic        o_powered,     // module on
    input wire logic        o_sample,      // tracking
    input wire logic [7:0]  o_trial,       // trial code
    input wire logic        o_wake,        // wake pulse
    input wire logic        s_axi_awvalid, // aw valid
    input wire logic        s_axi_awready, // aw ready
    input wire logic        s_axi_wvalid,  // w valid
    input wire logic        s_axi_wready,  // w ready
    input wire logic        s_axi_bvalid,  // b valid
    input wire logic        s_axi_bready,  // b ready
    input wire logic        s_axi_arvalid, // ar valid
    input wire logic        s_axi_arready, // ar ready
    input wire logic        s_axi_rvalid,  // r valid
    input wire logic        s_axi_rready,  // r ready
    input wire logic [31:0] s_axi_rdata,   // r data
    input wire logic [1:0]  s_axi_rresp    // r resp
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped early");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_awready && !s_axi_wready ##[0:1] s_axi_bvalid)
        else $error("write answer wrong");
    a_rresp_code: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0
        || s_axi_rresp == 2'h2) else $error("bad read response code");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_wake_pulse: assert property (o_wake |=> !o_wake)
        else $error("wake request longer than one cycle");
    a_wake_sleep: assert property (o_wake |-> $past(i_sleep))
        else $error("wake request while awake");
    a_trial_start: assert property ($fell(o_sample) && o_powered |-> o_trial == 8'h80)
        else $error("conversion did not start at mid code");
    a_sample_gap: assert property ($rose(o_sample) |-> !$past(o_sample, 2)
        && !$past(o_sample, 4)) else $error("acquisition resumed too soon");
endmodule // adcs_seq_checker
bind adcs_seq adcs_seq_checker u_chk (.i_sys_clk, .i_reset_n, .i_sleep, .o_powered,
    .o_sample, .o_trial, .o_wake, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

/* verification/adcs_analog_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// hold cap and comparator behind the sequencer
// ----------------------------------------
module adcs_analog_model (
    input  wire logic       i_clk,     // clock
    input  wire logic       i_powered, // module on
    input  wire logic       i_sample,  // tracking
    input  wire logic [7:0] i_trial,   // trial code
    input  wire logic [7:0] i_vin,     // input level
    output logic            o_comp     // above trial
);
    logic [7:0] held = 8'h00;
    logic       junk = 1'b0;
    always @(posedge i_clk) begin
        junk <= ~junk;
        if (i_sample) begin
            held <= i_vin;
        end
    end
    // unpowered comparator output means nothing, so it wanders
    assign o_comp = i_powered ? (held >= i_trial) : junk;
endmodule // adcs_analog_model

/* verification/test_adc_conversion_sequencer.sv */
`timescale 1ns/1ps
`include "adcs_cfg.svh"
module test_adc_conversion_sequencer;
    logic i_sys_clk, i_reset_n, i_sleep, i_comp_high, o_powered, o_sample, o_wake;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  o_channel, s_axi_bresp, s_axi_rresp, rd_r;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [7:0]  o_trial, vin;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    // a 2-clock bit period outruns the comparator sync, so sel 0 gets a flat input
    logic [7:0]  vals [5] = '{8'h00, 8'hA5, 8'hFF, 8'h3C, 8'h81};
    int n_errors = 0, cmp_count = 0, cyc = 0, n_wake = 0, t0, h, n, sel;
    adcs_seq uut (.i_sys_clk, .i_reset_n, .i_sleep, .i_comp_high, .o_powered, .o_sample,
        .o_channel, .o_trial, .o_wake, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    adcs_analog_model far (.i_clk(i_sys_clk), .i_powered(o_powered), .i_sample(o_sample),
        .i_trial(o_trial), .i_vin(vin), .o_comp(i_comp_high));
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (o_wake === 1'b1) n_wake <= n_wake + 1;
    end
    task automatic give_verdict;
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic guard(input int k);
        if (k > 400) begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int k;
        logic ta, tw, tb;
        k = 0;
        tb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb) begin
            @(negedge i_sys_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge i_sys_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            k++;
            guard(k);
        end
        s_axi_bready <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        int k;
        logic ta, tr;
        k = 0;
        tr = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tr) begin
            @(negedge i_sys_clk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            rd_d = s_axi_rdata;
            rd_r = s_axi_rresp;
            @(posedge i_sys_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            k++;
            guard(k);
        end
        s_axi_rready <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic wait_clear(input logic [3:0] a, input int b);
        int k;
        k = 0;
        do begin
            rd(a);
            k++;
            guard(k);
        end while (rd_d[b] !== 1'b0);
    endtask
    // power on first, go in a later write, after an acquisition wait
    task automatic start(input int s, input logic [7:0] v, input logic ien);
        logic [31:0] c;
        c = {24'h000000, s[1:0], 3'h0, ien, 2'h1};
        h = s == 0 ? `ADCS_HALF_2OSC : s == 1 ? `ADCS_HALF_8OSC : s == 2 ?
            `ADCS_HALF_32OSC : `ADCS_RC_HALF;
        vin <= v;
        wr(`ADCS_OFF_CTRL, c);
        repeat (20) @(posedge i_sys_clk);
        wr(`ADCS_OFF_CTRL, c | 32'h2);
        t0 = cyc;
    endtask
    initial begin
        {i_sleep, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
        {s_axi_rready, i_reset_n, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
        s_axi_wstrb = 4'hF;
        vin = 8'h00;
        repeat (4) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        @(posedge i_sys_clk);
        rd(`ADCS_OFF_CTRL);
        chk("ctrl after reset", rd_d, 32'h0);
        rd(4'hC);
        chk("unmapped response", rd_r, 32'h2);
        wr(`ADCS_OFF_CTRL, 32'h3);
        rd(`ADCS_OFF_CTRL);
        chk("go with power on", rd_d, 32'h1);
        wr(`ADCS_OFF_CTRL, 32'h19);
        @(negedge i_sys_clk);
        chk("channel", o_channel, 32'h3);
        @(posedge i_sys_clk);
        for (int s = 0; s < 5; s++) begin
            sel = s > 3 ? 3 : s;
            start(sel, vals[s], s == 3);
            i_sleep <= s >= 3;
            // go dropping marks completion; busy stays up through the hold
            wait_clear(`ADCS_OFF_CTRL, 1);
            i_sleep <= 1'b0;
            n = 19 * h + (sel == 3 ? `ADCS_INSTR_CYC : 0);
            chk("conversion time", cyc - t0 >= n - 4 && cyc - t0 <= n + 8, 1);
            wait_clear(`ADCS_OFF_STATUS, 1);
            n = n + `ADCS_HOLD_HALF * h;
            chk("hold time", cyc - t0 >= n - 4 && cyc - t0 <= n + 8, 1);
            chk("done flag", rd_d[0], 1);
            rd(`ADCS_OFF_RESULT);
            chk("result", rd_d, {24'h000000, vals[s]});
            rd(`ADCS_OFF_CTRL);
            chk("ctrl after done", rd_d[1:0], 2'h1);
            chk("wake count", n_wake, s >= 3);
            wr(`ADCS_OFF_STATUS, 32'h1);
        end
        // switch to the fastest divider mid-way; only a flat input stays exact
        start(2, 8'hFF, 1'b0);
        repeat (150) @(posedge i_sys_clk);
        wr(`ADCS_OFF_CTRL, 32'h03);
        wait_clear(`ADCS_OFF_CTRL, 1);
        chk("shortened conversion", cyc - t0 >= 150 && cyc - t0 <= 180, 1);
        rd(`ADCS_OFF_RESULT);
        chk("result after speed-up", rd_d, 32'hFF);
        wait_clear(`ADCS_OFF_STATUS, 1);
        wr(`ADCS_OFF_STATUS, 32'h1);
        wr(`ADCS_OFF_RESULT, 32'h5A);
        start(2, 8'hC3, 1'b0);
        repeat (40) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk("sample while converting", o_sample, 0);
        @(posedge i_sys_clk);
        wr(`ADCS_OFF_CTRL, 32'h81);
        t0 = cyc;
        n = 0;
        while (o_sample !== 1'b1) begin
            @(negedge i_sys_clk);
            n++;
            guard(n);
        end
        @(posedge i_sys_clk);
        chk("hold after abort", cyc - t0 >= 60 && cyc - t0 <= 72, 1);
        rd(`ADCS_OFF_STATUS);
        chk("no done on abort", rd_d[0], 0);
        start(1, 8'h44, 1'b0);
        repeat (10) @(posedge i_sys_clk);
        i_sleep <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk("powered in osc sleep", o_powered, 0);
        @(posedge i_sys_clk);
        rd(`ADCS_OFF_CTRL);
        chk("ctrl in osc sleep", rd_d[1:0], 2'h1);
        rd(`ADCS_OFF_RESULT);
        chk("result kept", rd_d, 32'h5A);
        i_sleep <= 1'b0;
        start(2, 8'h10, 1'b0);
        repeat (30) @(posedge i_sys_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        @(posedge i_sys_clk);
        rd(`ADCS_OFF_CTRL);
        chk("ctrl after mid reset", rd_d, 32'h0);
        rd(`ADCS_OFF_STATUS);
        chk("busy after mid reset", rd_d[1], 0);
        give_verdict();
    end
endmodule // test_adc_conversion_sequencer
